// >>> verilog/tap_link_regs.svh
// Constants for the boundary-scan test port and its controller.
`ifndef TAP_LINK_REGS_SVH
`define TAP_LINK_REGS_SVH
`define IR_LEN 4
`define IR_RESET_VAL 4'h1
`define IR_CAPTURE_VAL 4'h1
`define IR_IDCODE 4'h1
`define IR_BYPASS 4'hf
`define ID_LEN 32
`define ID_LAST 5'h1f
`define ID_CODE_VAL 32'h0000_0001
`define RESET_TMS_COUNT 3'h5
`define TCK_HALF_DIV 3'h3
`define TCK_HALF_DIV_W 3
`endif

// >>> verilog/tap_link_pkg.sv
// Package with the controller state type used by the device end and the bench.
`default_nettype none
package tap_link_pkg;
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4, ST_EXIT1_DR = 4'h5, ST_PAUSE_DR = 4'h6, ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SHIFT_IR = 4'hb,
        ST_EXIT1_IR = 4'hc, ST_PAUSE_IR = 4'hd, ST_EXIT2_IR = 4'he, ST_UPD_IR = 4'hf
    } tap_state_e;

    function automatic tap_state_e tap_step(input tap_state_e s, input logic m);
        case (s)
            ST_RESET: tap_step = m ? ST_RESET : ST_IDLE;
            ST_IDLE: tap_step = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_step = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: tap_step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: tap_step = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: tap_step = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: tap_step = m ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: tap_step = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tap_step = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: tap_step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: tap_step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: tap_step = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: tap_step = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: tap_step = m ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: tap_step = m ? ST_SEL_DR : ST_IDLE;
            default: tap_step = ST_RESET;
        endcase
    endfunction
endpackage
`default_nettype wire

// >>> verilog/tap_link_if.sv
// Interface carrying the four test pins and the optional test reset.
`timescale 1ns/1ps
`default_nettype none
interface tap_link_if;
    logic tck;
    logic tms;
    logic tms_drv;
    logic tdi;
    logic tdo_o;
    logic tdo_oe_n;
    logic tdo;
    logic trst_n;
    // The controller end always drives mode select; the device samplers other than the clock idle high.
    assign tms = tms_drv;
    assign tdo = tdo_oe_n ? 1'b1 : tdo_o;

    modport dev (input tck, input tms, input tdi, input trst_n, output tdo_o, output tdo_oe_n);
    modport ctl (output tck, output tms_drv, output tdi, output trst_n, input tdo, input tdo_oe_n);
endinterface
`default_nettype wire

// >>> verilog/tap_port_dev.sv
// Device end: test access port controller with id and bypass registers.
`timescale 1ns/1ps
`default_nettype none
`include "tap_link_regs.svh"
module tap_port_dev (
    input wire logic sys_clk,
    input wire logic rstn,
    tap_link_if.dev link,
    input wire logic fifo_oe_req,
    output logic fifo_out_oe_n,
    output logic tap_was_reset,
    output logic [3:0] tap_state
);
    import tap_link_pkg::*;

    typedef struct packed {
        logic [1:0] tck_sy;
        logic [1:0] tms_sy;
        logic [1:0] tdi_sy;
        logic [1:0] trst_sy;
        logic tck_prev;
        tap_state_e st;
        logic [`IR_LEN-1:0] ir_sh;
        logic [`IR_LEN-1:0] ir;
        logic [`ID_LEN-1:0] dr_sh;
        logic tdo_o;
        logic tdo_oe_n;
        logic was_reset;
        logic fifo_oe_n;
    } dev_s;

    dev_s cur_reg;
    dev_s cur_next;
    logic rise;
    logic fall;
    logic shifting;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cur_next = cur_reg;
        cur_next.tck_sy = {cur_reg.tck_sy[0], link.tck};
        cur_next.tms_sy = {cur_reg.tms_sy[0], link.tms};
        cur_next.tdi_sy = {cur_reg.tdi_sy[0], link.tdi};
        cur_next.trst_sy = {cur_reg.trst_sy[0], link.trst_n};
        cur_next.tck_prev = cur_reg.tck_sy[1];
        rise = cur_reg.tck_sy[1] && !cur_reg.tck_prev;
        fall = !cur_reg.tck_sy[1] && cur_reg.tck_prev;
        shifting = (cur_reg.st == ST_SHIFT_DR) || (cur_reg.st == ST_SHIFT_IR);
        if (rise) begin
            cur_next.st = tap_step(cur_reg.st, cur_reg.tms_sy[1]);
            case (cur_reg.st)
                ST_CAP_IR: cur_next.ir_sh = `IR_CAPTURE_VAL;
                ST_SHIFT_IR: cur_next.ir_sh = {cur_reg.tdi_sy[1], cur_reg.ir_sh[`IR_LEN-1:1]};
                ST_UPD_IR: cur_next.ir = cur_reg.ir_sh;
                ST_CAP_DR: begin
                    // Any unknown instruction falls back to bypass.
                    if (cur_reg.ir == `IR_IDCODE) begin
                        cur_next.dr_sh = `ID_CODE_VAL;
                    end else begin
                        cur_next.dr_sh = '0;
                    end
                end
                ST_SHIFT_DR: begin
                    if (cur_reg.ir == `IR_IDCODE) begin
                        cur_next.dr_sh = {cur_reg.tdi_sy[1], cur_reg.dr_sh[`ID_LEN-1:1]};
                    end else begin
                        cur_next.dr_sh[0] = cur_reg.tdi_sy[1];
                    end
                end
                default: begin
                end
            endcase
        end
        if (fall) begin
            // Output moves half a test clock after the shift edge.
            cur_next.tdo_oe_n = !shifting;
            if (cur_reg.st == ST_SHIFT_IR) begin
                cur_next.tdo_o = cur_reg.ir_sh[0];
            end else begin
                cur_next.tdo_o = cur_reg.dr_sh[0];
            end
        end
        if (!shifting) begin
            cur_next.tdo_oe_n = 1'b1;
        end
        // Arriving in reset by mode select alone counts at once, not only on the next edge.
        if (cur_reg.st == ST_RESET) begin
            cur_next.ir = `IR_RESET_VAL;
            cur_next.was_reset = 1'b1;
        end
        if (!cur_reg.trst_sy[1]) begin
            cur_next.st = ST_RESET;
            cur_next.ir = `IR_RESET_VAL;
            cur_next.was_reset = 1'b1;
            cur_next.tdo_oe_n = 1'b1;
        end
        cur_next.fifo_oe_n = !(cur_reg.was_reset && fifo_oe_req);
    end

    ////////////////////////////////////////////////////////////////////////////
    // System reset presets the sampling to idle levels and puts the controller in ST_IDLE without counting as a test reset,
    // so a port not yet reset through the test pins keeps the FIFO outputs floating.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_reg <= '{tck_sy: 2'h0, tms_sy: 2'h3, tdi_sy: 2'h3, trst_sy: 2'h3,
                         tck_prev: 1'b0, st: ST_IDLE,
                         ir_sh: '0, ir: '0, dr_sh: '0, tdo_o: 1'b0, tdo_oe_n: 1'b1,
                         was_reset: 1'b0, fifo_oe_n: 1'b1};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign link.tdo_o = cur_reg.tdo_o;
    assign link.tdo_oe_n = cur_reg.tdo_oe_n;
    assign fifo_out_oe_n = cur_reg.fifo_oe_n;
    assign tap_was_reset = cur_reg.was_reset;
    assign tap_state = cur_reg.st;
endmodule
`default_nettype wire

// >>> verilog/tap_port_ctl.sv
// Controller end: drives the test clock and shifts one bit per request.
`timescale 1ns/1ps
`default_nettype none
`include "tap_link_regs.svh"
module tap_port_ctl (
    input wire logic sys_clk,
    input wire logic rstn,
    tap_link_if.ctl link,
    input wire logic step_valid,
    input wire logic step_tms,
    input wire logic step_tdi,
    input wire logic trst_req,
    output logic step_ready,
    output logic tdo_bit,
    output logic tdo_bit_valid
);
    import tap_link_pkg::*;

    typedef enum logic [1:0] {
        C_IDLE = 2'h0, C_LOW = 2'h1, C_HIGH = 2'h2
    } ctl_state_e;

    typedef struct packed {
        ctl_state_e st;
        logic [`TCK_HALF_DIV_W-1:0] div;
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
        logic [1:0] tdo_sy;
        logic ready;
        logic bit_o;
        logic bit_v;
    } ctl_s;

    ctl_s cur_reg;
    ctl_s cur_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cur_next = cur_reg;
        cur_next.tdo_sy = {cur_reg.tdo_sy[0], link.tdo};
        cur_next.bit_v = 1'b0;
        // Test reset is only pulsed on request, otherwise idles high while scan is in use.
        cur_next.trst_n = !trst_req;
        case (cur_reg.st)
            C_IDLE: begin
                cur_next.ready = 1'b1;
                if (step_valid && cur_reg.ready) begin
                    cur_next.tms = step_tms;
                    cur_next.tdi = step_tdi;
                    cur_next.ready = 1'b0;
                    cur_next.div = '0;
                    cur_next.st = C_LOW;
                end
            end
            C_LOW: begin
                cur_next.div = cur_reg.div + 1'b1;
                if (cur_reg.div == `TCK_HALF_DIV) begin
                    cur_next.tck = 1'b1;
                    cur_next.div = '0;
                    cur_next.st = C_HIGH;
                end
            end
            C_HIGH: begin
                cur_next.div = cur_reg.div + 1'b1;
                if (cur_reg.div == `TCK_HALF_DIV) begin
                    // Sample the pin before the falling edge moves it again.
                    cur_next.bit_o = cur_reg.tdo_sy[1];
                    cur_next.bit_v = 1'b1;
                    cur_next.tck = 1'b0;
                    cur_next.st = C_IDLE;
                end
            end
            default: cur_next.st = C_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_reg <= '{st: C_IDLE, div: '0, tck: 1'b0, tms: 1'b1, tdi: 1'b1,
                         trst_n: 1'b1, tdo_sy: 2'h3, ready: 1'b0, bit_o: 1'b0,
                         bit_v: 1'b0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign link.tck = cur_reg.tck;
    assign link.tms_drv = cur_reg.tms;
    assign link.tdi = cur_reg.tdi;
    assign link.trst_n = cur_reg.trst_n;
    assign step_ready = cur_reg.ready;
    assign tdo_bit = cur_reg.bit_o;
    assign tdo_bit_valid = cur_reg.bit_v;
endmodule
`default_nettype wire

// >>> dv/tap_link_props.sv
// Checker for the test link wires between the controller end and the device end.
`timescale 1ns/1ps
`default_nettype none
module tap_link_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo_o,
    input wire logic tdo_oe_n,
    input wire logic trst_n
);
    logic tck_q_reg;
    logic [2:0] fall_cnt_reg;
    logic [2:0] high_cnt_reg;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // Clocks since the link clock fell, and rises in a row with mode select high.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tck_q_reg <= 1'b0;
            fall_cnt_reg <= 3'h7;
            high_cnt_reg <= 3'h0;
        end else begin
            tck_q_reg <= tck;
            if (tck_q_reg && !tck) begin
                fall_cnt_reg <= 3'h0;
            end else if (fall_cnt_reg != 3'h7) begin
                fall_cnt_reg <= fall_cnt_reg + 3'h1;
            end
            if (!tck_q_reg && tck) begin
                high_cnt_reg <= !tms ? 3'h0 : (high_cnt_reg == 3'h5) ? 3'h5 : high_cnt_reg + 3'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_high_then_fall;
        tck [*4] ##1 !tck;
    endsequence
    a_tck_high_len: assert property ($rose(tck) |-> s_high_then_fall)
        else $error("link clock high phase has the wrong length");
    a_tck_low_len: assert property ($fell(tck) |-> !tck [*4])
        else $error("link clock low phase too short");
    a_pins_steady_high: assert property ($rose(tck) |-> ($stable(tms) && $stable(tdi)) [*4])
        else $error("mode select or data in moved while clock high");
    a_pins_change_low: assert property (($changed(tms) || $changed(tdi)) |-> !tck && !$past(tck))
        else $error("mode select or data in moved near a rising edge");
    a_tdo_on_fall: assert property (!tdo_oe_n && $changed(tdo_o) |-> fall_cnt_reg <= 3'h5)
        else $error("data out changed away from a falling edge");
    a_oe_on_fall: assert property ($fell(tdo_oe_n) |-> fall_cnt_reg <= 3'h5)
        else $error("data out enabled away from a falling edge");
    a_trst_floats: assert property (!trst_n [*5] |-> tdo_oe_n)
        else $error("data out driven while test reset held");
    a_five_high_float: assert property (high_cnt_reg == 3'h5 |-> ##[0:6] tdo_oe_n)
        else $error("data out driven after five high mode selects");
endmodule
`default_nettype wire

// >>> dv/boundary_scan_tap_port_test.sv
// Self-checking bench joining the controller end and the device end.
`timescale 1ns/1ps
`default_nettype none
`include "tap_link_regs.svh"
module boundary_scan_tap_port_test;
    import tap_link_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic fifo_oe_req = 1'b0;
    logic step_valid = 1'b0;
    logic step_tms = 1'b1;
    logic step_tdi = 1'b1;
    logic trst_req = 1'b0;
    logic fifo_out_oe_n, tap_was_reset, step_ready, tdo_bit, tdo_bit_valid;
    logic [3:0] tap_state;
    logic [31:0] dout;
    int miscompares = 0;
    int checked = 0;
    // Each row holds the mode select bit, then the state it should lead to.
    logic [7:0] walk [50] = '{8'h12, 8'h19, 8'h10, 8'h10, 8'h10, 8'h01, 8'h01, 8'h12, 8'h03,
        8'h04, 8'h04, 8'h15, 8'h06, 8'h06, 8'h17, 8'h04, 8'h15, 8'h18, 8'h12, 8'h19, 8'h0a,
        8'h0b, 8'h1c, 8'h0d, 8'h1e, 8'h0b, 8'h1c, 8'h1f, 8'h01, 8'h12, 8'h03, 8'h15, 8'h06,
        8'h17, 8'h18, 8'h01, 8'h12, 8'h19, 8'h0a, 8'h1c, 8'h1f, 8'h12, 8'h03, 8'h04, 8'h15,
        8'h18, 8'h12, 8'h19, 8'h10, 8'h01};
    tap_link_if link ();
    tap_port_dev i_tap_port_dev (.sys_clk(sys_clk), .rstn(rstn), .link(link.dev),
        .fifo_oe_req(fifo_oe_req), .fifo_out_oe_n(fifo_out_oe_n),
        .tap_was_reset(tap_was_reset), .tap_state(tap_state));
    tap_port_ctl i_tap_port_ctl (.sys_clk(sys_clk), .rstn(rstn), .link(link.ctl),
        .step_valid(step_valid), .step_tms(step_tms), .step_tdi(step_tdi),
        .trst_req(trst_req), .step_ready(step_ready), .tdo_bit(tdo_bit),
        .tdo_bit_valid(tdo_bit_valid));
    tap_link_props i_tap_link_props (.sys_clk(sys_clk), .rstn(rstn), .tck(link.tck),
        .tms(link.tms), .tdi(link.tdi), .tdo_o(link.tdo_o), .tdo_oe_n(link.tdo_oe_n),
        .trst_n(link.trst_n));
    always #20 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One link clock per bit; a hung handshake counts as a mismatch.
    task automatic seq(input int n, input logic [31:0] ms, input logic [31:0] din);
        int w;
        for (int i = 0; i < n; i++) begin
            w = 0;
            while (step_ready !== 1'b1 && w < 40) begin
                @(posedge sys_clk);
                w++;
            end
            step_valid <= 1'b1;
            step_tms <= ms[i];
            step_tdi <= din[i];
            @(posedge sys_clk);
            step_valid <= 1'b0;
            do begin
                @(posedge sys_clk);
                w++;
            end while (tdo_bit_valid !== 1'b1 && w < 40);
            dout[i] = tdo_bit;
            if (w >= 40) miscompares++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        fifo_oe_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(tap_was_reset, 1'b0);
        chk(fifo_out_oe_n, 1'b1);
        chk(link.tdo_oe_n, 1'b1);
        chk(tap_state, ST_IDLE);
        foreach (walk[i]) begin
            seq(1, 32'(walk[i][4]), 32'h1);
            repeat (6) @(posedge sys_clk);
            chk(tap_state, walk[i][3:0]);
            chk(link.tdo_oe_n, !(walk[i][3:0] inside {ST_SHIFT_DR, ST_SHIFT_IR}));
        end
        chk(tap_was_reset, 1'b1);
        chk(fifo_out_oe_n, 1'b0);
        fifo_oe_req <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk(fifo_out_oe_n, 1'b1);
        seq(8, 32'h83, 32'hff);
        chk(dout[7:4], `IR_CAPTURE_VAL);
        chk(dout[3:0], 4'hf);
        seq(6, 32'h23, 32'h15);
        chk(dout[5:2], 4'hb);
        seq(11, 32'h307, 32'({`IR_IDCODE, 5'h00}));
        seq(3, 32'h1, 32'h0);
        seq(32, 32'h8000_0000, 32'h0);
        chk(dout, `ID_CODE_VAL);
        seq(3, 32'h2, 32'h7);
        repeat (6) @(posedge sys_clk);
        chk(link.tdo_oe_n, 1'b0);
        trst_req <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(tap_state, ST_RESET);
        chk(link.tdo_oe_n, 1'b1);
        trst_req <= 1'b0;
        fifo_oe_req <= 1'b1;
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(tap_state, ST_IDLE);
        chk(fifo_out_oe_n, 1'b1);
        seq(8, 32'hf9, 32'h0);
        repeat (4) @(posedge sys_clk);
        chk(tap_state, ST_RESET);
        chk(tap_was_reset, 1'b1);
        chk(fifo_out_oe_n, 1'b0);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        // Test reset follows the system reset and is held low for four link clocks, then released.
        trst_req <= 1'b1;
        seq(4, 32'h0, 32'h0);
        chk(tap_state, ST_RESET);
        chk(link.tdo_oe_n, 1'b1);
        chk(fifo_out_oe_n, 1'b0);
        trst_req <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk(tap_was_reset, 1'b1);
        chk(fifo_out_oe_n, 1'b0);
        results();
    end
    initial begin
        repeat (10000) @(posedge sys_clk);
        miscompares++;
        results();
    end
endmodule
`default_nettype wire
